// ### pcl_loader.sv
// Purpose: passive parallel configuration input with word pacing
// Assumes: clk 100 MHz; config clock from the host, may stop
// Notes:   decompression passes words through; decryption xors key
`timescale 1ns/10ps
`default_nettype none
`include "pcl_regs.svh"
// Summary of operation
// - with no decompression and no decryption one word per clock.
// - clocks per word follow bus width, decompression wins.
// - the spare clocks of a word period decode the word.
// - after power-up wait the fast or standard power-on delay.
// - config request low in user mode restarts configuration.
// - config complete rises only after all words arrive cleanly.
module pcl_loader
#(
    parameter int PorFastCycles = `PCL_POR_FAST_CYC,
    parameter int PorStdCycles  = `PCL_POR_STD_CYC,
    parameter int FifoDepth     = `PCL_FIFO_DEPTH
)
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                configClock,
    input  wire logic [31:0]         configData,
    input  wire logic                configRequestN,
    input  wire logic [4:0]          schemeSelectPins,
    input  wire logic [31:0]         expectedWords,
    input  wire logic [31:0]         cipherKey,
    output logic [31:0]              wordOut,
    output logic                     wordValid,
    input  wire logic                wordReady,
    output logic                     configComplete,
    output logic                     userMode,
    output logic                     loadError,
    output pcl_pkg::pcl_width_t      busWidth,
    output pcl_pkg::pcl_ratio_t      currentRatio
);
    import pcl_pkg::*;

    function automatic logic [31:0] maskData(input logic [31:0] d,
                                             input pcl_width_t w);
        case (w)
            PCL_W8:  return {24'h000000, d[7:0]};
            PCL_W16: return {16'h0000, d[15:0]};
            default: return d;
        endcase
    endfunction

    function automatic logic [3:0] bin2gray(input logic [3:0] b);
        return b ^ (b >> 1);
    endfunction

    // ****************************************************************
    // system side: pin synchronisers
    // ****************************************************************
    logic [`PCL_SEL_BITS-1:0] selS1, selS2, selS3, selF;
    logic                     reqS1, reqS2, reqS3, reqF;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            selS1 <= '0;
            selS2 <= '0;
            selS3 <= '0;
            selF  <= '0;
            reqS1 <= 1'b1;
            reqS2 <= 1'b1;
            reqS3 <= 1'b1;
            reqF  <= 1'b1;
        end
        else
        begin
            selS1 <= schemeSelectPins;
            selS2 <= selS1;
            selS3 <= selS2;
            reqS1 <= configRequestN;
            reqS2 <= reqS1;
            reqS3 <= reqS2;
            if (selS2 == selS3)
                selF <= selS3;
            if (reqS2 == reqS3)
                reqF <= reqS3;
        end
    end

    // ****************************************************************
    // link side: reset release and quasi-static settings
    // ****************************************************************
    logic        linkGo;
    logic        linkRst1, linkRstn;
    logic [3:0]  cfgL1, cfgL2;
    logic [31:0] expL1, expL2;
    logic [3:0]  cfgStrap;
    pcl_width_t  widthL;
    pcl_ratio_t  ratioL;

    always_ff @(posedge configClock or negedge linkGo)
    begin
        if (!linkGo)
        begin
            linkRst1 <= 1'b0;
            linkRstn <= 1'b0;
        end
        else
        begin
            linkRst1 <= 1'b1;
            linkRstn <= linkRst1;
        end
    end

    // settings settle during the two reset-release edges, before word one
    always_ff @(posedge configClock or negedge linkGo)
    begin
        if (!linkGo)
        begin
            cfgL1 <= '0;
            cfgL2 <= '0;
            expL1 <= '0;
            expL2 <= '0;
        end
        else
        begin
            cfgL1 <= cfgStrap;
            cfgL2 <= cfgL1;
            expL1 <= expectedWords;
            expL2 <= expL1;
        end
    end

    assign widthL = pcl_width_t'(cfgL2[1:0]);
    assign ratioL = pcl_ratio(widthL, cfgL2[2], cfgL2[3]);

    // ****************************************************************
    // link side: word pacing, decode and ring write
    // ****************************************************************
    logic [3:0]  phase;
    logic [31:0] held;
    logic [31:0] commitWord;
    logic [31:0] ringMem [8];
    logic [3:0]  wrBin, wrGray;
    logic [3:0]  rdGrayL1, rdGrayL2, rdGrayL3;
    logic [3:0]  rdBin, rdGray;
    logic        doneFall;
    logic        ringFull, commitNow, loadDoneL, overflowL;
    logic [31:0] wordsTaken;
    logic [1:0]  fallCount;

    assign ringFull  = (wrGray == {~rdGrayL3[3:2], rdGrayL3[1:0]});
    assign commitNow = (phase == ratioL - 4'h1) && !loadDoneL;
    // ratio one commits the bus itself, longer ratios the held word
    assign commitWord = ((ratioL == `PCL_RATIO_1)
                        ? maskData(configData, widthL) : held)
                        ^ (cfgL2[3] ? cipherKey : 32'h00000000);

    always_ff @(posedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
            phase <= 4'h0;
        else if (!loadDoneL)
            phase <= commitNow ? 4'h0 : phase + 4'h1;
    end

    always_ff @(posedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
            held <= 32'h00000000;
        else if (phase == 4'h0)
            held <= maskData(configData, widthL);
    end

    always_ff @(posedge configClock)
    begin
        if (commitNow && !ringFull)
            ringMem[wrBin[2:0]] <= commitWord;
    end

    always_ff @(posedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
        begin
            wrBin      <= 4'h0;
            wrGray     <= 4'h0;
            wordsTaken <= 32'h00000000;
            loadDoneL  <= 1'b0;
            overflowL  <= 1'b0;
        end
        else if (commitNow)
        begin
            if (ringFull)
                overflowL <= 1'b1;
            else
            begin
                wrBin  <= wrBin + 4'h1;
                wrGray <= bin2gray(wrBin + 4'h1);
            end
            wordsTaken <= wordsTaken + 32'h1;
            loadDoneL  <= (wordsTaken + 32'h1 == expL2);
        end
    end

    always_ff @(posedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
        begin
            rdGrayL1 <= 4'h0;
            rdGrayL2 <= 4'h0;
            rdGrayL3 <= 4'h0;
        end
        else
        begin
            rdGrayL1 <= rdGray;
            rdGrayL2 <= rdGrayL1;
            rdGrayL3 <= rdGrayL2;
        end
    end

    // two falling edges after the last word open user mode
    // the falling edge of the last word's own clock does not count
    always_ff @(negedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
            doneFall <= 1'b0;
        else
            doneFall <= loadDoneL;
    end

    always_ff @(negedge configClock or negedge linkRstn)
    begin
        if (!linkRstn)
            fallCount <= 2'h0;
        else if (doneFall && fallCount != `PCL_USER_FALL_EDGES)
            fallCount <= fallCount + 2'h1;
    end

    // ****************************************************************
    // system side: ring read into the FIFO
    // ****************************************************************
    logic [3:0] wrGrayS1, wrGrayS2, wrGrayS3;
    logic [2:0] stS1, stS2, stS3, stF;
    logic       ringEmpty;

    pcl_stream_if #(.Width(32)) ringToFifo ();
    pcl_stream_if #(.Width(32)) fifoToUser ();

    assign ringEmpty        = (rdGray == wrGrayS3);
    assign ringToFifo.valid = !ringEmpty && linkGo;
    assign ringToFifo.data  = ringMem[rdBin[2:0]];
    assign fifoToUser.ready = wordReady;
    assign wordValid        = fifoToUser.valid;
    assign wordOut          = fifoToUser.data;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrGrayS1 <= 4'h0;
            wrGrayS2 <= 4'h0;
            wrGrayS3 <= 4'h0;
            stS1     <= 3'h0;
            stS2     <= 3'h0;
            stS3     <= 3'h0;
            stF      <= 3'h0;
        end
        else
        begin
            wrGrayS1 <= wrGray;
            wrGrayS2 <= wrGrayS1;
            wrGrayS3 <= wrGrayS2;
            stS1 <= {overflowL, fallCount == `PCL_USER_FALL_EDGES,
                     loadDoneL};
            stS2 <= stS1;
            stS3 <= stS2;
            if (stS2 == stS3)
                stF <= stS3;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdBin  <= 4'h0;
            rdGray <= 4'h0;
        end
        else if (!linkGo)
        begin
            rdBin  <= 4'h0;
            rdGray <= 4'h0;
        end
        else if (ringToFifo.valid && ringToFifo.ready)
        begin
            rdBin  <= rdBin + 4'h1;
            rdGray <= bin2gray(rdBin + 4'h1);
        end
    end

    pcl_fifo #(.Width(32), .Depth(FifoDepth)) u_fifo
    (
        .clk     (clk),
        .resetn  (resetn),
        .inPort  (ringToFifo),
        .outPort (fifoToUser)
    );

    // ****************************************************************
    // system side: power-on delay and configuration sequence
    // ****************************************************************
    pcl_state_t  state;
    logic [31:0] porCount;
    logic [31:0] porTarget;

    assign porTarget = selF[`PCL_SEL_FAST_BIT] ? 32'(PorFastCycles)
                                               : 32'(PorStdCycles);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state    <= PCL_ST_POR;
            porCount <= 32'h00000000;
            linkGo   <= 1'b0;
            cfgStrap <= 4'h0;
        end
        else
        begin
            case (state)
                PCL_ST_POR:
                begin
                    porCount <= porCount + 32'h1;
                    if (porCount >= porTarget - 32'h1)
                    begin
                        cfgStrap <= {selF[`PCL_SEL_CRYPT_BIT],
                                     selF[`PCL_SEL_DECOMP_BIT],
                                     selF[`PCL_SEL_WIDTH_HI:
                                          `PCL_SEL_WIDTH_LO]};
                        linkGo   <= 1'b1;
                        state    <= PCL_ST_LOAD;
                    end
                end
                PCL_ST_LOAD:
                    if (stF[1] && !stF[2])
                        state <= PCL_ST_USER;
                PCL_ST_USER:
                    if (!reqF)
                    begin
                        linkGo <= 1'b0;
                        state  <= PCL_ST_HOLD;
                    end
                PCL_ST_HOLD:
                    if (reqF)
                    begin
                        linkGo <= 1'b1;
                        state  <= PCL_ST_LOAD;
                    end
                default:
                    state <= PCL_ST_POR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            configComplete <= 1'b0;
            userMode       <= 1'b0;
            loadError      <= 1'b0;
            busWidth       <= PCL_W8;
            currentRatio   <= `PCL_RATIO_1;
        end
        else
        begin
            configComplete <= linkGo && stF[0] && !stF[2];
            userMode       <= (state == PCL_ST_USER);
            loadError      <= linkGo && stF[2];
            busWidth       <= pcl_width_t'(cfgStrap[1:0]);
            currentRatio   <= pcl_ratio(pcl_width_t'(cfgStrap[1:0]),
                                        cfgStrap[2], cfgStrap[3]);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_plain_ratio;
        @(posedge clk) disable iff (!resetn)
        (!cfgStrap[2] && !cfgStrap[3]) |=> currentRatio == `PCL_RATIO_1;
    endproperty
    a_plain_ratio: assert property (p_plain_ratio)
        else $error("plain scheme not one clock per word");

    property p_decomp_ratio;
        @(posedge clk) disable iff (!resetn)
        (cfgStrap[2] && cfgStrap[1:0] == 2'b10)
            |=> currentRatio == `PCL_RATIO_8;
    endproperty
    a_decomp_ratio: assert property (p_decomp_ratio)
        else $error("wide decompression ratio wrong");

    property p_phase_bound;
        @(posedge configClock) disable iff (!linkRstn)
        phase < ratioL;
    endproperty
    a_phase_bound: assert property (p_phase_bound)
        else $error("word phase beyond ratio");

    property p_commit_at_end;
        @(posedge configClock) disable iff (!linkRstn)
        (wrBin != $past(wrBin)) |-> $past(phase) == $past(ratioL) - 4'h1;
    endproperty
    a_commit_at_end: assert property (p_commit_at_end)
        else $error("word written outside period end");

    property p_por_wait;
        @(posedge clk) disable iff (!resetn)
        (state == PCL_ST_POR) ##1 (state == PCL_ST_LOAD)
            |-> $past(porCount) >= $past(porTarget) - 32'h1;
    endproperty
    a_por_wait: assert property (p_por_wait)
        else $error("power-on delay cut short");

    property p_reconfig;
        @(posedge clk) disable iff (!resetn)
        (state == PCL_ST_USER && !reqF)
            |=> (state == PCL_ST_HOLD && !linkGo) ##1 !configComplete;
    endproperty
    a_reconfig: assert property (p_reconfig)
        else $error("request low did not restart configuration");

    property p_complete_clean;
        @(posedge clk) disable iff (!resetn)
        $rose(configComplete) |-> $past(stF[0]) && !$past(stF[2])
                                  && state != PCL_ST_POR;
    endproperty
    a_complete_clean: assert property (p_complete_clean)
        else $error("complete rose without full clean load");

    property p_user_after_complete;
        @(posedge clk) disable iff (!resetn)
        $rose(userMode) |-> configComplete;
    endproperty
    a_user_after_complete: assert property (p_user_after_complete)
        else $error("user mode without config complete");

    c_user: cover property (@(posedge clk) $rose(userMode));
    c_reconfig: cover property (@(posedge clk) state == PCL_ST_HOLD);
    c_slow_ratio: cover property (@(posedge configClock)
                                  ratioL == `PCL_RATIO_8 && commitNow);
endmodule // pcl_loader
`default_nettype wire

// ### pcl_regs.svh
// Purpose: constants of the parallel configuration loader
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

// ****************************************************************
// clock and power-on timing
// ****************************************************************
`define PCL_CLK_MHZ          100
`define PCL_POR_FAST_MIN_MS  4
`define PCL_POR_FAST_MAX_MS  12
`define PCL_POR_STD_MIN_MS   100
`define PCL_POR_STD_MAX_MS   300
`define PCL_POR_FAST_CYC     (`PCL_POR_FAST_MIN_MS * 1000 * `PCL_CLK_MHZ)
`define PCL_POR_STD_CYC      (`PCL_POR_STD_MIN_MS * 1000 * `PCL_CLK_MHZ)

// ****************************************************************
// scheme select pin fields
// ****************************************************************
`define PCL_SEL_WIDTH_LO     0
`define PCL_SEL_WIDTH_HI     1
`define PCL_SEL_FAST_BIT     2
`define PCL_SEL_DECOMP_BIT   3
`define PCL_SEL_CRYPT_BIT    4
`define PCL_SEL_BITS         5

// ****************************************************************
// clocks per word and link counts
// ****************************************************************
`define PCL_RATIO_1          4'h1
`define PCL_RATIO_2          4'h2
`define PCL_RATIO_4          4'h4
`define PCL_RATIO_8          4'h8
`define PCL_USER_FALL_EDGES  2'h2
`define PCL_FIFO_DEPTH       16

`endif

// ### pcl_pkg.sv
// Purpose: shared types of the parallel configuration loader
// Assumes: pcl_regs.svh holds the numbers
// Notes:   ratio decoding is shared by link and system logic
package pcl_pkg;
`include "pcl_regs.svh"

    typedef enum logic [1:0]
    {
        PCL_W8  = 2'b00,
        PCL_W16 = 2'b01,
        PCL_W32 = 2'b10
    } pcl_width_t;

    typedef enum logic [1:0]
    {
        PCL_ST_POR  = 2'b00,
        PCL_ST_LOAD = 2'b01,
        PCL_ST_USER = 2'b10,
        PCL_ST_HOLD = 2'b11
    } pcl_state_t;

    typedef logic [3:0] pcl_ratio_t;

    // clocks per word; decompression wins over decryption
    function automatic pcl_ratio_t pcl_ratio(input pcl_width_t w,
                                             input logic decomp,
                                             input logic crypt);
        pcl_ratio_t r;
        r = `PCL_RATIO_1;
        case (w)
            PCL_W16: r = decomp ? `PCL_RATIO_4
                       : (crypt ? `PCL_RATIO_2 : `PCL_RATIO_1);
            PCL_W32: r = decomp ? `PCL_RATIO_8
                       : (crypt ? `PCL_RATIO_4 : `PCL_RATIO_1);
            default: r = decomp ? `PCL_RATIO_2 : `PCL_RATIO_1;
        endcase
        return r;
    endfunction
endpackage

// ### pcl_stream_if.sv
// Purpose: valid/ready word stream between loader modules
// Assumes: one clock for both ends
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface pcl_stream_if #(parameter int Width = 32);
    logic             valid;
    logic             ready;
    logic [Width-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### pcl_fifo.sv
// Purpose: synchronous word FIFO in the configuration data path
// Assumes: one clock, asynchronous active-low reset
// Notes:   ready and valid are combinational from the count
`timescale 1ns/10ps
`default_nettype none
module pcl_fifo
#(
    parameter int Width = 32,
    parameter int Depth = 16
)
(
    input  wire logic clk,
    input  wire logic resetn,
    pcl_stream_if.snk inPort,
    pcl_stream_if.src outPort
);
    import pcl_pkg::*;
    localparam int Aw = $clog2(Depth);

    logic [Width-1:0] mem [Depth];
    logic [Aw-1:0]    wrPtr;
    logic [Aw-1:0]    rdPtr;
    logic [Aw:0]      count;
    logic             push;
    logic             pop;

    // ****************************************************************
    // handshake
    // ****************************************************************
    assign inPort.ready  = (count != (Aw+1)'(Depth));
    assign outPort.valid = (count != '0);
    assign outPort.data  = mem[rdPtr];
    assign push = inPort.valid && inPort.ready;
    assign pop  = outPort.valid && outPort.ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inPort.data;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wrPtr <= (wrPtr == Aw'(Depth-1)) ? '0 : wrPtr + 1'b1;
            if (pop)
                rdPtr <= (rdPtr == Aw'(Depth-1)) ? '0 : rdPtr + 1'b1;
            count <= count + (Aw+1)'(push) - (Aw+1)'(pop);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_fifo_bound;
        @(posedge clk) disable iff (!resetn)
        count <= (Aw+1)'(Depth);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo count above depth");

    property p_fifo_full_stalls;
        @(posedge clk) disable iff (!resetn)
        (!inPort.ready && !pop) |=> (count == $past(count));
    endproperty
    a_fifo_full_stalls: assert property (p_fifo_full_stalls)
        else $error("fifo count moved while full");

    c_fifo_full: cover property (@(posedge clk) !inPort.ready);
endmodule // pcl_fifo
`default_nettype wire

// ### pcl_host_model.sv
// Purpose: host model of the config clock and data bus
// Assumes: 30 ns config clock, stopped low between transfers
// Notes:   can scramble the bus off the sample edge
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// config host
// ****************************************************************
module pcl_host_model
(
    output logic        configClock,
    output logic [31:0] configData
);
    initial
    begin
        configClock = 1'b0;
        configData  = 32'h0;
    end
    // one clock, phase unrelated to the system clock
    task automatic pulse();
        #8 configClock = 1'b1;
        #15 configClock = 1'b0;
        #7;
    endtask
    task automatic send(input logic [31:0] w, input int r, input bit scr);
        configData = w;
        for (int i = 0; i < r; i++)
        begin
            #8 configClock = 1'b1;
            #15 configClock = 1'b0;
            #3;
            if (scr || i == r - 1)
                configData = ~w;
            #4;
        end
    endtask
endmodule // pcl_host_model
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench of the parallel config loader
// Assumes: short power-on counts, host model on the link
// Notes:   monitor checks popped words against a queue
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
`define WAITV(c) begin for (int k = 0; k < 2000 && !(c); k++) \
    @(negedge clk); \
    if (!(c)) begin err_count++; \
    $display("mismatch wait exp 1 got 0"); final_report(); end end
// ****************************************************************
// bench
// ****************************************************************
module tb_top;
    import pcl_pkg::*;
    logic        clk;
    logic        resetn;
    logic        configClock;
    logic [31:0] configData;
    logic        configRequestN;
    logic [4:0]  schemeSelectPins;
    logic [31:0] expectedWords;
    logic [31:0] cipherKey;
    logic [31:0] wordOut;
    logic        wordValid;
    logic        wordReady = 1'b0;
    logic        configComplete;
    logic        userMode;
    logic        loadError;
    pcl_width_t  busWidth;
    pcl_ratio_t  currentRatio;
    logic [31:0] q[$];
    logic [31:0] head;
    logic [31:0] mask;
    integer      seed;
    int          ratio;
    int          err_count = 0;
    int          tests_run = 0;
    bit          crypt;
    bit          stall = 1'b0;

    pcl_host_model host
    (
        .configClock (configClock),
        .configData  (configData)
    );
    pcl_loader #(.PorFastCycles(50), .PorStdCycles(100)) DUT
    (
        .clk              (clk),
        .resetn           (resetn),
        .configClock      (configClock),
        .configData       (configData),
        .configRequestN   (configRequestN),
        .schemeSelectPins (schemeSelectPins),
        .expectedWords    (expectedWords),
        .cipherKey        (cipherKey),
        .wordOut          (wordOut),
        .wordValid        (wordValid),
        .wordReady        (wordReady),
        .configComplete   (configComplete),
        .userMode         (userMode),
        .loadError        (loadError),
        .busWidth         (busWidth),
        .currentRatio     (currentRatio)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
        wordReady <= stall ? 1'b0 : 1'($random(seed));
    always @(posedge clk)
    begin
        if (wordValid === 1'b1 && wordReady === 1'b1)
        begin
            head = ~wordOut;
            if (q.size() > 0)
                head = q.pop_front();
            `CHK("wordOut", head, wordOut);
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic start(input logic [4:0] pins);
        @(negedge clk);
        resetn = 1'b0;
        schemeSelectPins = pins;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (pins[2] ? 80 : 130) @(negedge clk);
        mask = pins[1] ? 32'hffffffff : (pins[0] ? 32'hffff : 32'hff);
        crypt = pins[4];
        ratio = pins[3] ? 2 << pins[1:0] : (crypt ? 1 << pins[1:0] : 1);
        `CHK("complete", 1'b0, configComplete);
        `CHK("width", pins[1:0], busWidth);
        `CHK("ratio", pcl_ratio_t'(ratio), currentRatio);
    endtask
    task automatic load(input int n, input bit scr, input int keep);
        logic [31:0] w;
        host.pulse();
        host.pulse();
        for (int i = 0; i < n; i++)
        begin
            w = $random(seed);
            if (i < keep)
                q.push_back((w & mask) ^ (crypt ? cipherKey : 32'h0));
            host.send(w, ratio, scr);
        end
    endtask
    task automatic run(input logic [4:0] pins);
        start(pins);
        expectedWords = 32'h4;
        cipherKey = $random(seed);
        load(4, pins[0], 4);
        `WAITV(configComplete === 1'b1)
        `CHK("early user", 1'b0, userMode);
        `CHK("error", 1'b0, loadError);
        host.pulse();
        repeat (10) @(negedge clk);
        `CHK("one edge", 1'b0, userMode);
        host.pulse();
        `WAITV(userMode === 1'b1 && q.size() == 0)
        configRequestN = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("restart", 2'b00, {configComplete, userMode});
        configRequestN = 1'b1;
        repeat (20) @(negedge clk);
        expectedWords = 32'h2;
        load(2, 1'b1, 2);
        `WAITV(configComplete === 1'b1 && q.size() == 0)
        `CHK("reload", 1'b1, configComplete);
    endtask

    initial
    begin
        seed = 32'hddf5;
        resetn = 1'b0;
        configRequestN = 1'b1;
        schemeSelectPins = 5'h0;
        expectedWords = 32'h0;
        cipherKey = 32'h0;
        for (int m = 0; m < 12; m++)
            run({m[0], m[1], 1'(m % 3 != 0), 2'(m >> 2)});
        // ready held low: ring and fifo fill, later words dropped
        stall = 1'b1;
        start(5'b00110);
        expectedWords = 32'd28;
        load(28, 1'b0, 24);
        repeat (20) @(negedge clk);
        `CHK("overflow", 2'b10, {loadError, configComplete});
        stall = 1'b0;
        `WAITV(wordValid === 1'b0 && q.size() == 0)
        final_report();
    end
endmodule // tb_top
`default_nettype wire
